// *** verilog/irq_pkg.sv ***
`default_nettype none
package irq_pkg;
   // ==========================================
   // isr numbering and fixed ranks
   localparam int         NUM_ISR       = 32;
   localparam int         NUM_RANKS     = 27;
   localparam int         REQ_W         = 25;
   localparam int         REQ_FIRST     = 2;
   localparam int         VEC_SHIFT     = 3;
   localparam logic [4:0] ISR_RESET     = 5'h00;
   localparam logic [4:0] ISR_NMI       = 5'h01;
   localparam logic [4:0] ISR_SEC_FIRST = 5'h10;
   localparam logic [4:0] ISR_SEC_LAST  = 5'h17;
   localparam logic [4:0] ISR_BUS_FAULT = 5'h18;
   localparam logic [4:0] ISR_DATALOG   = 5'h19;
   localparam logic [4:0] ISR_KERNEL    = 5'h1A;
   localparam logic [31:0] MASKABLE_MASK = 32'h07FF_FFFC;
   // index 0 holds the isr of rank 1 (highest)
   localparam logic [4:0] RANK_ISR [NUM_RANKS] = '{
      5'h00, 5'h01, 5'h18, 5'h02, 5'h10, 5'h03, 5'h04, 5'h05, 5'h11,
      5'h06, 5'h07, 5'h08, 5'h12, 5'h09, 5'h0A, 5'h0B, 5'h13, 5'h0C,
      5'h0D, 5'h14, 5'h15, 5'h0E, 5'h0F, 5'h16, 5'h17, 5'h19, 5'h1A};
   // ==========================================
   // register map (byte addresses)
   localparam logic [7:0] ADR_FLAG_LO  = 8'h00;
   localparam logic [7:0] ADR_FLAG_HI  = 8'h04;
   localparam logic [7:0] ADR_IER_LO   = 8'h08;
   localparam logic [7:0] ADR_IER_HI   = 8'h0C;
   localparam logic [7:0] ADR_TCE_LO   = 8'h10;
   localparam logic [7:0] ADR_TCE_HI   = 8'h14;
   localparam logic [7:0] ADR_BASE_PRI = 8'h18;
   localparam logic [7:0] ADR_BASE_SEC = 8'h1C;
   localparam logic [7:0] ADR_MODE     = 8'h20;
   localparam logic [7:0] ADR_DSP      = 8'h24;
   localparam logic [7:0] ADR_SSP      = 8'h28;
   localparam logic [7:0] ADR_SOFT     = 8'h2C;
   localparam int         MODE_GID     = 0;
   localparam int         MODE_DEBUG_EVENT_MASK    = 1;
   localparam int         MODE_EMU_REG_WRITE_ALLOW  = 2;
   localparam int         MODE_STACKS  = 3;
   localparam int         MODE_BUSY    = 4;
   localparam logic [2:0] MODE_RESET   = 3'h3;
   localparam int         SOFT_TRAP    = 5;
   localparam int         SOFT_PEND    = 6;
   localparam logic [1:0] STARTUP_CYCLES = 2'h3;
   // ==========================================
   // branch sequencer
   typedef enum logic [1:0] {ST_IDLE, ST_BRANCH, ST_FETCH, ST_SERVICE}
      seq_state_e;
endpackage
`default_nettype wire

// *** verilog/irq_rank_picker.sv ***
`timescale 1ns/1ps
`default_nettype none
module irq_rank_picker
   import irq_pkg::*;
(
   input  wire logic [31:0] cand_i,
   output logic             any_o,
   output logic [4:0]       win_o
);
   // ==========================================
   // fixed rank search
   // walk from lowest rank up so the best rank is assigned last
   always_comb begin
      any_o = 1'b0;
      win_o = ISR_RESET;
      for (int r = NUM_RANKS - 1; r >= 0; r--) begin
         if (cand_i[RANK_ISR[r]]) begin
            any_o = 1'b1; // RULE4
            win_o = RANK_ISR[r]; // RULE5 RULE6
         end
      end
   end
endmodule // irq_rank_picker
`default_nettype wire

// *** verilog/irq_vector_calc.sv ***
`timescale 1ns/1ps
`default_nettype none
module irq_vector_calc
   import irq_pkg::*;
#(
   parameter int BASE_W = 16
)(
   input  wire logic [4:0]        isr_i,
   input  wire logic [BASE_W-1:0] base_pri_i,
   input  wire logic [BASE_W-1:0] base_sec_i,
   output logic [BASE_W+7:0]      addr_o
);
   // ==========================================
   // vector address: base page plus isr times eight
   logic sec;
   assign sec = (isr_i >= ISR_SEC_FIRST) && (isr_i <= ISR_SEC_LAST);
   // one 8-bit offset per isr keeps all 32 entries distinct
   assign addr_o = {sec ? base_sec_i : base_pri_i, // RULE3
                    isr_i, 3'h0}; // RULE1 RULE2
   initial begin
      if (BASE_W < 1 || BASE_W > 16)
         $error("BASE_W must lie in 1..16");
   end
endmodule // irq_vector_calc
`default_nettype wire

// *** verilog/irq_vector_ctrl.sv ***
// Notes on behaviour
// RULE1 - thirty-two isrs, each with own vector
// RULE2 - vector is primary base plus isr times eight
// RULE3 - isrs 16 to 23 use secondary base
// RULE4 - simultaneous hardware requests served one by one
// RULE5 - reset, nmi, bus fault lead; datalog, kernel last
// RULE6 - middle ranks follow the fixed isr order
// RULE7 - isrs 27 to 31 software only
// RULE8 - isr0 reset, isr1 nmi or software
// RULE9 - maskable set: vectors 2-23 plus three events
// RULE10 - bus error raises isr 24
// RULE11 - datalog completion raises isr 25
// RULE12 - breakpoint or watchpoint raises isr 26
// RULE13 - flag latches until ack, clear or reset
// RULE14 - acknowledge needs enable bit set
// RULE15 - standard flow needs global disable clear
// RULE16 - branch flushes younger instructions only
// RULE17 - acknowledge clears the flag
// RULE18 - branch saves mode bits for return
// RULE19 - branch sets disable, debug mask; clears allow; the code leaves disable unchanged on a software trap
// RULE20 - disabled requests ignored; return resumes program
// RULE21 - emulation halt serves time-critical only
// RULE22 - software may run any maskable isr
// RULE23 - sources wait three cycles after reset
// RULE24 - nothing taken until both stacks written; the code takes isr 0 reset without them
// RULE25 - time-critical flow ignores global disable
// RULE26 - set beats clear in same cycle
`timescale 1ns/1ps
`default_nettype none
module irq_vector_ctrl
   import irq_pkg::*;
#(
   parameter int BASE_W = 16
)(
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire logic [7:0]        wb_adr_i,
   input  wire logic [31:0]       wb_dat_i,
   input  wire logic [3:0]        wb_sel_i,
   input  wire logic              wb_we_i,
   input  wire logic              wb_cyc_i,
   input  wire logic              wb_stb_i,
   output logic [31:0]            wb_dat_o,
   output logic                   wb_ack_o,
   input  wire logic [21:0]       hw_irq_i,
   input  wire logic              bus_fault_irq_i,
   input  wire logic              datalog_done_irq_i,
   input  wire logic              kernel_event_irq_i,
   input  wire logic              nmi_n_i,
   input  wire logic              emu_halt_i,
   input  wire logic              reti_i,
   output logic                   flush_o,
   output logic                   ctx_save_o,
   output logic                   vector_valid_o,
   output logic [BASE_W+7:0]      vector_addr_o,
   output logic [4:0]             isr_num_o,
   output logic                   in_service_o,
   output logic                   global_irq_disable_o,
   output logic                   debug_event_mask_o,
   output logic                   emu_reg_write_allow_o
);
   initial begin
      if (BASE_W < 1 || BASE_W > 16)
         $error("BASE_W must lie in 1..16");
   end

   // byte-lane merge into a 16-bit register
   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] d,
                                           input logic [3:0]  sel);
      merge16 = old;
      if (sel[0]) merge16[7:0] = d[7:0];
      if (sel[1]) merge16[15:8] = d[15:8];
   endfunction

   // ==========================================
   // declarations
   logic [REQ_W-1:0]  req_meta;
   logic [REQ_W-1:0]  req_sync;
   logic [REQ_W-1:0]  req_last;
   logic              nmi_meta;
   logic              nmi_sync;
   logic              nmi_last;
   logic [1:0]        start_cnt;
   logic              started;
   logic [31:0]       flag;
   logic [31:0]       ier;
   logic [31:0]       tce;
   logic [31:0]       set_vec;
   logic [31:0]       clr_sw;
   logic [31:0]       clr_ack;
   logic [31:0]       cand;
   logic [BASE_W-1:0] base_pri;
   logic [BASE_W-1:0] base_sec;
   logic [2:0]        mode;
   logic [2:0]        saved_mode;
   logic [15:0]       dsp;
   logic [15:0]       system_stack_ptr;
   logic              dsp_done;
   logic              ssp_done;
   logic              stacks_ready;
   logic              reset_pend;
   logic              nmi_pend;
   logic              sw_pend;
   logic [4:0]        sw_num;
   logic              sw_trap;
   logic              sw_ok;
   logic              hw_any;
   logic [4:0]        hw_win;
   logic              take;
   logic [4:0]        take_num;
   logic              take_maskable;
   logic              mask_gate;
   logic [4:0]        cur_num;
   logic [BASE_W+7:0] calc_addr;
   logic              wr;
   logic [31:0]       rd_data;
   seq_state_e        state;

   // ==========================================
   // request synchronisers and edge detect
   // pins and peripheral lines may be asynchronous, so two flops first
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         req_meta <= '0;
         req_sync <= '0;
         req_last <= '0;
         nmi_meta <= 1'b1;
         nmi_sync <= 1'b1;
         nmi_last <= 1'b1;
      end else begin
         req_meta <= {kernel_event_irq_i, datalog_done_irq_i,
                      bus_fault_irq_i, hw_irq_i};
         req_sync <= req_meta;
         req_last <= req_sync;
         nmi_meta <= nmi_n_i;
         nmi_sync <= nmi_meta;
         nmi_last <= nmi_sync;
      end
   end

   // requests before the startup window are not recognised
   always_ff @(posedge clk_i) begin
      if (rst_i)
         start_cnt <= '0;
      else if (start_cnt != STARTUP_CYCLES)
         start_cnt <= start_cnt + 2'h1;
   end
   assign started = (start_cnt == STARTUP_CYCLES); // RULE23

   // rising edges of vectors 2-23, bus fault, datalog, kernel event
   assign set_vec = {5'h00,
                     (req_sync & ~req_last) & {REQ_W{started}}, // RULE9
                     2'h0}; // RULE10 RULE11 RULE12

   // ==========================================
   // register bus slave
   assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;

   // ack one cycle after the request, dropped the cycle after
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
      end else begin
         wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
         wb_dat_o <= (wb_cyc_i && wb_stb_i && !wb_ack_o) ? rd_data : '0;
      end
   end

   // read mux; unmapped addresses read zero
   always_comb begin
      rd_data = '0;
      if (wb_adr_i == ADR_FLAG_LO)
         rd_data[15:0] = flag[15:0];
      else if (wb_adr_i == ADR_FLAG_HI)
         rd_data[15:0] = flag[31:16];
      else if (wb_adr_i == ADR_IER_LO)
         rd_data[15:0] = ier[15:0];
      else if (wb_adr_i == ADR_IER_HI)
         rd_data[15:0] = ier[31:16];
      else if (wb_adr_i == ADR_TCE_LO)
         rd_data[15:0] = tce[15:0];
      else if (wb_adr_i == ADR_TCE_HI)
         rd_data[15:0] = tce[31:16];
      else if (wb_adr_i == ADR_BASE_PRI)
         rd_data[BASE_W-1:0] = base_pri;
      else if (wb_adr_i == ADR_BASE_SEC)
         rd_data[BASE_W-1:0] = base_sec;
      else if (wb_adr_i == ADR_MODE)
         rd_data[MODE_BUSY:0] = {in_service_o, stacks_ready, mode};
      else if (wb_adr_i == ADR_DSP)
         rd_data[15:0] = dsp;
      else if (wb_adr_i == ADR_SSP)
         rd_data[15:0] = system_stack_ptr;
      else if (wb_adr_i == ADR_SOFT)
         rd_data[SOFT_PEND:0] = {sw_pend, sw_trap, isr_num_o};
   end

   // enable, time-critical enable and vector bases
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ier <= '0;
         tce <= '0;
         base_pri <= '0;
         base_sec <= '0;
      end else if (wr) begin
         if (wb_adr_i == ADR_IER_LO)
            ier[15:0] <= merge16(ier[15:0], wb_dat_i, wb_sel_i)
                         & MASKABLE_MASK[15:0];
         else if (wb_adr_i == ADR_IER_HI)
            ier[31:16] <= merge16(ier[31:16], wb_dat_i, wb_sel_i)
                          & MASKABLE_MASK[31:16];
         else if (wb_adr_i == ADR_TCE_LO)
            tce[15:0] <= merge16(tce[15:0], wb_dat_i, wb_sel_i)
                         & MASKABLE_MASK[15:0];
         else if (wb_adr_i == ADR_TCE_HI)
            tce[31:16] <= merge16(tce[31:16], wb_dat_i, wb_sel_i)
                          & MASKABLE_MASK[31:16];
         else if (wb_adr_i == ADR_BASE_PRI)
            base_pri <= BASE_W'(merge16(16'(base_pri), wb_dat_i, wb_sel_i));
         else if (wb_adr_i == ADR_BASE_SEC)
            base_sec <= BASE_W'(merge16(16'(base_sec), wb_dat_i, wb_sel_i));
      end
   end

   // stack pointers; both must be written before anything but reset is taken
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dsp <= '0;
         system_stack_ptr <= '0;
         dsp_done <= 1'b0;
         ssp_done <= 1'b0;
      end else if (wr && wb_adr_i == ADR_DSP) begin
         dsp <= merge16(dsp, wb_dat_i, wb_sel_i);
         dsp_done <= 1'b1;
      end else if (wr && wb_adr_i == ADR_SSP) begin
         system_stack_ptr <= merge16(system_stack_ptr, wb_dat_i, wb_sel_i);
         ssp_done <= 1'b1;
      end
   end
   assign stacks_ready = dsp_done && ssp_done; // RULE24

   // ==========================================
   // flags: write one to clear, hardware set wins
   always_comb begin
      clr_sw = '0;
      if (wr && wb_adr_i == ADR_FLAG_LO)
         clr_sw[15:0] = merge16(16'h0000, wb_dat_i, wb_sel_i);
      else if (wr && wb_adr_i == ADR_FLAG_HI)
         clr_sw[31:16] = merge16(16'h0000, wb_dat_i, wb_sel_i);
   end
   assign clr_ack = (take && take_maskable) ? (32'h1 << take_num) : '0;

   always_ff @(posedge clk_i) begin
      if (rst_i)
         flag <= '0; // RULE13
      else
         flag <= ((flag & ~(clr_sw | clr_ack)) | set_vec) // RULE17 RULE26
                 & MASKABLE_MASK;
   end

   // nonmaskable sources: reset after release, nmi pin falling edge
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         reset_pend <= 1'b1; // RULE8
         nmi_pend <= 1'b0;
      end else begin
         if (take && !sw_ok && take_num == ISR_RESET)
            reset_pend <= 1'b0;
         if (!nmi_sync && nmi_last && started)
            nmi_pend <= 1'b1;
         else if (take && !sw_ok && take_num == ISR_NMI)
            nmi_pend <= 1'b0;
      end
   end

   // software interrupt request; a second write while pending is dropped
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sw_pend <= 1'b0;
         sw_num <= ISR_RESET;
         sw_trap <= 1'b0;
      end else if (wr && wb_adr_i == ADR_SOFT && wb_sel_i[0] && !sw_pend) begin
         sw_pend <= 1'b1; // RULE22
         sw_num <= wb_dat_i[4:0]; // RULE7
         sw_trap <= wb_dat_i[SOFT_TRAP];
      end else if (take && sw_ok) begin
         sw_pend <= 1'b0;
      end
   end

   // ==========================================
   // acknowledge decision
   // halted in emulation: time-critical bit replaces the global disable
   assign mask_gate = emu_halt_i ? 1'b1 : !mode[MODE_GID]; // RULE15 RULE25
   assign cand = {flag[31:2] & ier[31:2] // RULE14 RULE20
                  & (emu_halt_i ? tce[31:2] : '1) // RULE21
                  & {30{mask_gate && stacks_ready}},
                  nmi_pend && stacks_ready, reset_pend};

   irq_rank_picker u_picker (
      .cand_i (cand),
      .any_o  (hw_any),
      .win_o  (hw_win)
   );

   // software wins over hardware; software reset bypasses the stack gate
   assign sw_ok = sw_pend && (stacks_ready || sw_num == ISR_RESET);
   assign take = (state == ST_IDLE) && (sw_ok || hw_any);
   assign take_num = sw_ok ? sw_num : hw_win;
   assign take_maskable = !sw_ok && MASKABLE_MASK[take_num];

   // ==========================================
   // branch sequencer
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= ST_IDLE;
      end else begin
         case (state)
            ST_IDLE: begin
               if (take)
                  state <= ST_BRANCH;
            end
            ST_BRANCH: begin
               state <= ST_FETCH;
            end
            ST_FETCH: begin
               state <= ST_SERVICE;
            end
            ST_SERVICE: begin
               if (reti_i)
                  state <= ST_IDLE; // RULE20
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // pipeline strobes, then the vector fetch address
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flush_o <= 1'b0;
         ctx_save_o <= 1'b0;
         vector_valid_o <= 1'b0;
         vector_addr_o <= '0;
         isr_num_o <= ISR_RESET;
         cur_num <= ISR_RESET;
         in_service_o <= 1'b0;
      end else begin
         flush_o <= take; // RULE16
         ctx_save_o <= take; // RULE18
         vector_valid_o <= (state == ST_BRANCH);
         if (state == ST_BRANCH)
            vector_addr_o <= calc_addr; // RULE2
         if (take) begin
            isr_num_o <= take_num;
            cur_num <= take_num;
            in_service_o <= 1'b1;
         end else if (state == ST_SERVICE && reti_i) begin
            in_service_o <= 1'b0;
         end
      end
   end

   irq_vector_calc #(.BASE_W(BASE_W)) u_vec (
      .isr_i      (cur_num),
      .base_pri_i (base_pri),
      .base_sec_i (base_sec),
      .addr_o     (calc_addr)
   );

   // ==========================================
   // mode bits: forced on branch (disable bit left as is on a software trap), restored on return
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode <= MODE_RESET;
         saved_mode <= MODE_RESET;
      end else if (take) begin
         saved_mode <= mode; // RULE18
         if (!(sw_ok && sw_trap))
            mode[MODE_GID] <= 1'b1; // RULE19
         mode[MODE_DEBUG_EVENT_MASK] <= 1'b1;
         mode[MODE_EMU_REG_WRITE_ALLOW] <= 1'b0;
      end else if (state == ST_SERVICE && reti_i) begin
         mode <= saved_mode;
      end else if (wr && wb_adr_i == ADR_MODE && wb_sel_i[0]) begin
         mode <= wb_dat_i[2:0];
      end
   end
   assign global_irq_disable_o = mode[MODE_GID];
   assign debug_event_mask_o = mode[MODE_DEBUG_EVENT_MASK];
   assign emu_reg_write_allow_o = mode[MODE_EMU_REG_WRITE_ALLOW];

   // ==========================================
   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   property p_branch_seq;
      take |=> flush_o && ctx_save_o ##1 vector_valid_o && !flush_o;
   endproperty
   a_branch_seq: assert property (p_branch_seq) // RULE16
      else $error("branch strobes out of order");

   property p_vec_pri;
      vector_valid_o && !(isr_num_o inside {[ISR_SEC_FIRST:ISR_SEC_LAST]}) |->
         vector_addr_o == {base_pri, isr_num_o, 3'h0};
   endproperty
   a_vec_pri: assert property (p_vec_pri) // RULE2
      else $error("primary vector address wrong");

   property p_vec_sec;
      vector_valid_o && (isr_num_o inside {[ISR_SEC_FIRST:ISR_SEC_LAST]}) |->
         vector_addr_o == {base_sec, isr_num_o, 3'h0};
   endproperty
   a_vec_sec: assert property (p_vec_sec) // RULE3
      else $error("secondary vector address wrong");

   property p_flag_clear;
      take && take_maskable && !set_vec[take_num] |=>
         !flag[$past(take_num)];
   endproperty
   a_flag_clear: assert property (p_flag_clear) // RULE17
      else $error("flag not cleared on acknowledge");

   property p_flag_set;
      (set_vec != '0) |=> (flag & $past(set_vec)) == $past(set_vec);
   endproperty
   a_flag_set: assert property (p_flag_set) // RULE26
      else $error("hardware request lost");

   property p_enable;
      take && take_maskable |-> ier[take_num] && stacks_ready;
   endproperty
   a_enable: assert property (p_enable) // RULE14
      else $error("acknowledged a disabled interrupt");

   property p_global;
      take && take_maskable && !emu_halt_i |-> !mode[MODE_GID];
   endproperty
   a_global: assert property (p_global) // RULE15
      else $error("acknowledged while globally disabled");

   property p_time_crit;
      take && take_maskable && emu_halt_i |-> tce[take_num];
   endproperty
   a_time_crit: assert property (p_time_crit) // RULE21
      else $error("non time-critical taken in halt");

   property p_fresh_ctx;
      take && !(sw_ok && sw_trap) |=>
         global_irq_disable_o && debug_event_mask_o &&
         !emu_reg_write_allow_o;
   endproperty
   a_fresh_ctx: assert property (p_fresh_ctx) // RULE19
      else $error("fresh context not forced");

   property p_stacks;
      take && take_num != ISR_RESET |-> stacks_ready;
   endproperty
   a_stacks: assert property (p_stacks) // RULE24
      else $error("taken before stacks written");

   property p_restore;
      state == ST_SERVICE && reti_i |=> mode == $past(saved_mode);
   endproperty
   a_restore: assert property (p_restore) // RULE18
      else $error("mode not restored on return");

   property p_ack;
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
   endproperty
   a_ack: assert property (p_ack)
      else $error("bus ack timing wrong");

   c_maskable: cover property (take && take_maskable);
   c_soft: cover property (take && sw_ok);
   c_nmi: cover property (take && !sw_ok && take_num == ISR_NMI);
   c_return: cover property (state == ST_SERVICE && reti_i);
endmodule // irq_vector_ctrl
`default_nettype wire

// *** testbench/irq_source_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// request sources: peripherals, pins, debug
module irq_source_model (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic [24:0] fire_i,
   output logic [21:0]      hw_irq_o,
   output logic             bus_fault_irq_o,
   output logic             datalog_done_irq_o,
   output logic             kernel_event_irq_o
);
   logic [1:0] age;
   // counts cycles since reset left
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         age <= 2'h0;
      end else if (age != 2'h3) begin
         age <= age + 2'h1;
      end
   end
   // early edges would be lost, so lines stay low until then
   always_ff @(posedge clk_i) begin
      if (rst_i || age != 2'h3) begin
         {kernel_event_irq_o, datalog_done_irq_o, bus_fault_irq_o,
          hw_irq_o} <= 25'h0;
      end else begin
         {kernel_event_irq_o, datalog_done_irq_o, bus_fault_irq_o,
          hw_irq_o} <= fire_i;
      end
   end
endmodule // irq_source_model
`default_nettype wire

// *** testbench/irq_vector_ctrl_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module irq_vector_ctrl_test
   import irq_pkg::*;
;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic [7:0]  adr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic        we = 1'b0;
   logic        cyc = 1'b0;
   logic        reti = 1'b0;
   logic        halt = 1'b0;
   logic [24:0] fire = 25'h0;
   logic [31:0] rdat;
   logic        ack, flush, save, vvalid, insvc, gid, debug_event_mask, eal;
   logic        bf, dl, ke;
   logic [23:0] vaddr;
   logic [4:0]  isr;
   logic [21:0] hw;
   int          fails = 0;
   int          samples_checked = 0;
   int          cycles = 0;
   int          takes = 0;
   int          vals = 0;
   int          judged = 0;
   logic        was_flush = 1'b0;
   logic        seen_seq;
   logic [1:0]  seen_ctx;
   logic [2:0]  seen_mode;
   logic [4:0]  seen_isr;
   logic [23:0] seen_addr;
   // ==========================================
   // design and request sources
   irq_vector_ctrl i_irq_vector_ctrl (
      .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat),
      .wb_sel_i(4'hF), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(cyc),
      .wb_dat_o(rdat), .wb_ack_o(ack), .hw_irq_i(hw),
      .bus_fault_irq_i(bf), .datalog_done_irq_i(dl),
      .kernel_event_irq_i(ke), .nmi_n_i(1'b1), .emu_halt_i(halt),
      .reti_i(reti), .flush_o(flush), .ctx_save_o(save),
      .vector_valid_o(vvalid), .vector_addr_o(vaddr), .isr_num_o(isr),
      .in_service_o(insvc), .global_irq_disable_o(gid),
      .debug_event_mask_o(debug_event_mask), .emu_reg_write_allow_o(eal));
   irq_source_model i_irq_source_model (
      .clk_i(clk_i), .rst_i(rst_i), .fire_i(fire), .hw_irq_o(hw),
      .bus_fault_irq_o(bf), .datalog_done_irq_o(dl),
      .kernel_event_irq_o(ke));
   // ==========================================
   // clock, take counter and hang guard
   initial begin
      forever #4 clk_i = ~clk_i;
   end
   // branch strobes last one cycle, so they are caught here for later
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      was_flush <= flush;
      if (flush === 1'b1) begin
         takes <= takes + 1;
         seen_ctx <= {save, insvc};
         seen_isr <= isr;
         seen_mode <= {eal, debug_event_mask, gid};
      end
      if (vvalid === 1'b1) begin
         vals <= vals + 1;
         seen_addr <= vaddr;
         seen_seq <= was_flush;
      end
      if (cycles == 3000) begin
         fails++;
         give_verdict();
      end
   end
   task automatic give_verdict();
      $display("checked %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic check(string what, logic [31:0] exp, logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("BAD %s exp %h got %h", what, exp, got);
      end
   endtask
   // classic single cycle; held until ack is sampled
   task automatic wb(logic [7:0] a, logic w, logic [31:0] d,
                     output logic [31:0] r);
      adr <= a;
      we <= w;
      wdat <= d;
      cyc <= 1'b1;
      do @(posedge clk_i); while (ack !== 1'b1);
      r = rdat;
      cyc <= 1'b0;
      @(posedge clk_i);
   endtask
   // waits for a captured branch, judges it, then returns from it
   task automatic expect_take(logic [4:0] num, logic [23:0] va);
      while (vals == judged) @(posedge clk_i);
      judged++;
      check("ctx", 32'h3, {30'h0, seen_ctx});
      check("isr", {27'h0, num}, {27'h0, seen_isr});
      check("mode", 32'h3, {29'h0, seen_mode});
      check("valid", 32'h1, {31'h0, seen_seq});
      check("addr", {8'h0, va}, {8'h0, seen_addr});
      reti <= 1'b1;
      @(posedge clk_i);
      reti <= 1'b0;
   endtask
   // ==========================================
   // scenarios
   task automatic t_reset();
      expect_take(5'h00, 24'h0);
      check("gid", 32'h1, {31'h0, gid});
      $display("reset take done");
   endtask
   task automatic t_gate();
      logic [31:0] r;
      int          t0;
      wb(ADR_BASE_PRI, 1'b1, 32'h12, r);
      wb(ADR_BASE_SEC, 1'b1, 32'h34, r);
      wb(ADR_IER_LO, 1'b1, 32'hFFFF, r);
      wb(ADR_IER_HI, 1'b1, 32'h07FF, r);
      wb(ADR_MODE, 1'b1, 32'h4, r);
      t0 = takes;
      fire <= 25'h0000008;
      repeat (12) @(posedge clk_i);
      check("gated", t0, takes);
      wb(ADR_DSP, 1'b1, 32'h100, r);
      wb(ADR_SSP, 1'b1, 32'h200, r);
      expect_take(5'h05, 24'h001228);
      @(posedge clk_i);
      check("resume", 32'h4, {29'h0, eal, debug_event_mask, gid});
      check("idle", 32'h0, {31'h0, insvc});
      $display("stack gate done");
   endtask
   task automatic t_rank();
      logic [31:0] r;
      fire <= 25'h0404002;
      expect_take(5'h18, 24'h0012C0);
      expect_take(5'h10, 24'h003480);
      expect_take(5'h03, 24'h001218);
      wb(ADR_FLAG_LO, 1'b0, 32'h0, r);
      check("flag lo", 32'h0, r);
      $display("rank order done");
   endtask
   task automatic t_mask();
      logic [31:0] r;
      int          t0;
      fire <= 25'h0;
      wb(ADR_IER_LO, 1'b1, 32'h0, r);
      t0 = takes;
      fire <= 25'h0000004;
      repeat (8) @(posedge clk_i);
      wb(ADR_FLAG_LO, 1'b0, 32'h0, r);
      check("latched", 32'h10, r);
      wb(ADR_MODE, 1'b1, 32'h1, r);
      wb(ADR_IER_LO, 1'b1, 32'hFFFF, r);
      repeat (4) @(posedge clk_i);
      check("masked", t0, takes);
      wb(ADR_MODE, 1'b1, 32'h0, r);
      expect_take(5'h04, 24'h001220);
      $display("masking done");
   endtask
   task automatic t_halt();
      logic [31:0] r;
      int          t0;
      wb(ADR_MODE, 1'b1, 32'h1, r);
      halt <= 1'b1;
      t0 = takes;
      fire <= 25'h0000001;
      repeat (8) @(posedge clk_i);
      check("tc gated", t0, takes);
      wb(ADR_TCE_LO, 1'b1, 32'h4, r);
      expect_take(5'h02, 24'h001210);
      halt <= 1'b0;
      $display("halt done");
   endtask
   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_gate();
      t_rank();
      t_mask();
      t_halt();
      give_verdict();
   end
endmodule // irq_vector_ctrl_test
`default_nettype wire
